// File: src/dfa_pkg.sv
// Package for the full-address DMA channel: register map, field layout, types
package dfa_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB)
  // ==========================================================================
  localparam logic [7:0] OFF_SRC    = 8'h00;
  localparam logic [7:0] OFF_DST    = 8'h04;
  localparam logic [7:0] OFF_CNT_A  = 8'h08;
  localparam logic [7:0] OFF_CNT_B  = 8'h0c;
  localparam logic [7:0] OFF_CTL_A  = 8'h10;
  localparam logic [7:0] OFF_CTL_B  = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CA_ENABLE  = 7;
  localparam int CA_WORD    = 6;
  localparam int CA_SDIR    = 5;
  localparam int CA_SSTEP   = 4;
  localparam int CA_IRQ_EN  = 3;
  localparam int CA_ACT_HI  = 2;
  localparam int CA_ACT_MID = 1;
  localparam int CA_BLOCK   = 0;
  localparam int CB_MASTER  = 7;
  localparam int CB_DDIR    = 5;
  localparam int CB_DSTEP   = 4;
  localparam int CB_AREA    = 3;
  localparam int CB_ACT_LSB = 0;

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [7:0]  TOP_BYTE    = 8'hff;
  localparam logic [15:0] CNT16_ZERO  = 16'h0000;
  localparam logic [7:0]  CNT8_ZERO   = 8'h00;
  localparam logic [15:0] CNT16_ONE   = 16'h0001;
  localparam logic [7:0]  CNT8_ONE    = 8'h01;
  localparam logic [23:0] STEP_BYTE   = 24'h000001;
  localparam logic [23:0] STEP_WORD   = 24'h000002;
  localparam logic [2:0]  ACT_BURST   = 3'h0;
  localparam logic [2:0]  ACT_STEAL   = 3'h2;
  localparam logic [2:0]  ACT_LEVEL   = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_STEP  = 2'b11
  } dfa_state_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dfa_apb_req_t;

  // System bus master request bundle
  typedef struct packed {
    logic        req;
    logic        write;
    logic        word;
    logic [31:0] addr;
    logic [15:0] wdata;
  } dfa_bus_req_t;

endpackage : dfa_pkg

// File: src/dfa_channel.sv
// Full-address DMA channel: APB registers, transfer engine and bus master
// ============================================================================
// Functional notes
// R01 - Full address mode only when both upper activation-select bits of control A are 1
// R02 - Source address register feeds reads, destination address register feeds writes
// R03 - Top address byte ignores writes and always reads all ones
// R04 - Reset and standby never initialise address or count registers
// R05 - Fixed peripheral address register is never used for transfers
// R06 - Normal mode: count A decrements per transfer, ends at zero, count B unused
// R07 - Block mode: count A high byte counts block, reloads from low byte at zero
// R08 - Block mode: count B decrements per block, whole transfer ends at zero
// R09 - Channel enabled only when channel enable and master enable are both 1
// R10 - Auto-request starts at once, otherwise wait for a transfer request
// R11 - Channel enable self-clears on completion; requests ignored while it is 0
// R12 - Enable bit set only by a write following a read that saw it 0
// R13 - Transfer-end interrupt on enable clear when interrupt enable bit is 1
// R14 - Source address fixed, or stepped up/down by 1 or 2 after each transfer
// R15 - Control A bit 0 selects normal (0) or block transfer mode (1)
// R16 - Software loads equal block size into both count A bytes for repeat
// R17 - Control A resets to zero on reset and on standby entry
// R18 - Interrupt from NMI clears master enable, suspending; setting it again resumes
// R19 - Destination address fixed, or stepped up/down by 1 or 2 after each transfer
// R20 - Block mode: control B bit 3 picks destination (0) or source (1) block area
// R21 - Each transfer reads source then writes destination before any update
// ============================================================================
module dfa_channel (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  standby,
  input  wire logic                  nmi,
  input  wire logic                  transfer_request,
  output dfa_pkg::dfa_bus_req_t      bus_req,
  input  wire logic                  bus_ack,
  input  wire logic [15:0]           bus_rdata,
  output logic                       transfer_end_interrupt,
  output logic                       busy
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    dfa_pkg::dfa_state_t state;
    logic [23:0] src;
    logic [23:0] dst;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [7:0]  ctl_a;
    logic [7:0]  ctl_b;
    logic        arm_a;
    logic        arm_b;
    logic        mid_block;
    logic [23:0] blk_start;
    logic        req_d;
    logic        req_pend;
    logic        irq;
    logic [31:0] prdata;
    logic        pslverr;
    dfa_pkg::dfa_bus_req_t bus;
  } dfa_regs_t;

  // One state word: st_nxt is built whole, st_r registers it
  dfa_regs_t              st_r;
  dfa_regs_t              st_nxt;
  dfa_pkg::dfa_apb_req_t  apb;

  assign apb = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Any other offset answers with pslverr
  function automatic logic reg_valid(input logic [7:0] a);
    reg_valid = (a == dfa_pkg::OFF_SRC)   || (a == dfa_pkg::OFF_DST)   ||
                (a == dfa_pkg::OFF_CNT_A) || (a == dfa_pkg::OFF_CNT_B) ||
                (a == dfa_pkg::OFF_CTL_A) || (a == dfa_pkg::OFF_CTL_B) ||
                (a == dfa_pkg::OFF_STATUS);
  endfunction

  // Stored addresses are 24 bits; the top byte is a constant
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                            input logic dir, input logic word);
    logic [23:0] d;
    d = word ? dfa_pkg::STEP_WORD : dfa_pkg::STEP_BYTE;
    if (!en) begin
      step_addr = a;
    end else if (dir) begin
      step_addr = a - d;
    end else begin
      step_addr = a + d;
    end
  endfunction

  // ==========================================================================
  // Decoded control
  // ==========================================================================
  logic       full_mode;
  logic       enabled;
  logic       block_mode;
  logic [2:0] act_code;
  logic       auto_req;
  logic       level_req;
  logic       req_edge;
  logic       req_hit;
  logic       apb_acc;
  logic       apb_setup;

  always_comb begin
    full_mode  = st_r.ctl_a[dfa_pkg::CA_ACT_HI] & st_r.ctl_a[dfa_pkg::CA_ACT_MID];  // [R01]
    enabled    = full_mode & st_r.ctl_a[dfa_pkg::CA_ENABLE]
                 & st_r.ctl_b[dfa_pkg::CB_MASTER];                                   // [R09]
    block_mode = st_r.ctl_a[dfa_pkg::CA_BLOCK];                                      // [R15]
    act_code   = st_r.ctl_b[dfa_pkg::CB_ACT_LSB +: 3];
    // Block mode ignores the code: every block needs an edge
    auto_req   = !block_mode && ((act_code == dfa_pkg::ACT_BURST) ||
                                 (act_code == dfa_pkg::ACT_STEAL));
    level_req  = !block_mode && (act_code == dfa_pkg::ACT_LEVEL);
    // Edge register resets low, like the idle request pin
    req_edge   = transfer_request & ~st_r.req_d;
    req_hit    = level_req ? transfer_request : st_r.req_pend;
    // pready is tied high, so each access phase is one cycle
    apb_setup  = apb.psel & ~apb.penable;
    apb_acc    = apb.psel & apb.penable;
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic        start;
    logic        consume;
    logic        finished;
    logic        blk_done;
    logic [7:0]  hi_dec;
    logic [15:0] cnt_dec;
    logic [7:0]  wr_ctl;
    logic        old_en;
    start    = 1'b0;
    consume  = 1'b0;
    finished = 1'b0;
    blk_done = 1'b0;
    hi_dec   = 8'h00;
    cnt_dec  = 16'h0000;
    wr_ctl   = 8'h00;
    old_en   = st_r.ctl_a[dfa_pkg::CA_ENABLE];
    st_nxt   = st_r;
    st_nxt.irq   = 1'b0;
    st_nxt.req_d = transfer_request;

    // Transfer engine
    unique case (st_r.state)
      dfa_pkg::ST_IDLE: begin
        // A suspended block restarts without a new request
        start = enabled && (auto_req || req_hit || st_r.mid_block);  // [R10]
        if (start) begin
          consume = !auto_req && !st_r.mid_block;
          if (block_mode && !st_r.mid_block) begin
            st_nxt.mid_block = 1'b1;
            st_nxt.blk_start = st_r.ctl_b[dfa_pkg::CB_AREA] ? st_r.src : st_r.dst;  // [R20]
          end
          // Source feeds the read; the fixed peripheral address has no path here
          st_nxt.bus.req   = 1'b1;                                      // [R05]
          st_nxt.bus.write = 1'b0;
          st_nxt.bus.word  = st_r.ctl_a[dfa_pkg::CA_WORD];
          st_nxt.bus.addr  = {dfa_pkg::TOP_BYTE, st_r.src};             // [R02]
          st_nxt.state     = dfa_pkg::ST_READ;
        end
      end

      dfa_pkg::ST_READ: begin
        // Read word goes straight out as write data
        if (bus_ack) begin
          st_nxt.bus.write = 1'b1;
          st_nxt.bus.addr  = {dfa_pkg::TOP_BYTE, st_r.dst};             // [R02]
          st_nxt.bus.wdata = bus_rdata;                                 // [R21]
          st_nxt.state     = dfa_pkg::ST_WRITE;
        end
      end

      dfa_pkg::ST_WRITE: begin
        // Bus released for the single update cycle
        if (bus_ack) begin
          st_nxt.bus.req   = 1'b0;
          st_nxt.bus.write = 1'b0;
          st_nxt.state     = dfa_pkg::ST_STEP;                          // [R21]
        end
      end

      dfa_pkg::ST_STEP: begin
        // Both addresses step by the size set in control A
        st_nxt.src = step_addr(st_r.src, st_r.ctl_a[dfa_pkg::CA_SSTEP],
                               st_r.ctl_a[dfa_pkg::CA_SDIR],
                               st_r.ctl_a[dfa_pkg::CA_WORD]);           // [R14]
        st_nxt.dst = step_addr(st_r.dst, st_r.ctl_b[dfa_pkg::CB_DSTEP],
                               st_r.ctl_b[dfa_pkg::CB_DDIR],
                               st_r.ctl_a[dfa_pkg::CA_WORD]);           // [R19]
        if (block_mode) begin
          hi_dec = st_r.cnt_a[15:8] - dfa_pkg::CNT8_ONE;                // [R07]
          st_nxt.cnt_a[15:8] = hi_dec;
          // A block size of zero wraps and moves 256 units
          if (hi_dec == dfa_pkg::CNT8_ZERO) begin
            blk_done = 1'b1;
            st_nxt.cnt_a[15:8] = st_r.cnt_a[7:0];                       // [R07]
            cnt_dec = st_r.cnt_b - dfa_pkg::CNT16_ONE;                  // [R08]
            st_nxt.cnt_b = cnt_dec;
            finished = (cnt_dec == dfa_pkg::CNT16_ZERO);                // [R08]
            // Block area restarts at its first address for the next block
            if (st_r.ctl_b[dfa_pkg::CB_AREA]) begin
              st_nxt.src = st_r.blk_start;                              // [R20]
            end else begin
              st_nxt.dst = st_r.blk_start;                              // [R20]
            end
          end
        end else begin
          cnt_dec = st_r.cnt_a - dfa_pkg::CNT16_ONE;                    // [R06]
          st_nxt.cnt_a = cnt_dec;
          finished = (cnt_dec == dfa_pkg::CNT16_ZERO);                  // [R06]
        end
        if (blk_done) begin
          st_nxt.mid_block = 1'b0;
        end
        if (finished) begin
          st_nxt.ctl_a[dfa_pkg::CA_ENABLE] = 1'b0;                      // [R11]
          st_nxt.mid_block = 1'b0;
        end
        // Burst keeps the bus; steal and requested modes give one idle cycle
        if (!finished && enabled && ((block_mode && !blk_done) ||
            (!block_mode && act_code == dfa_pkg::ACT_BURST))) begin
          st_nxt.bus.req   = 1'b1;
          st_nxt.bus.word  = st_r.ctl_a[dfa_pkg::CA_WORD];
          st_nxt.bus.addr  = {dfa_pkg::TOP_BYTE, st_nxt.src};
          st_nxt.state     = dfa_pkg::ST_READ;
        end else begin
          st_nxt.state     = dfa_pkg::ST_IDLE;
        end
      end
    endcase

    // Request latch; a new edge in the consuming cycle is kept
    st_nxt.req_pend = st_r.ctl_a[dfa_pkg::CA_ENABLE]
                      & (req_edge | (st_r.req_pend & ~consume));        // [R11]

    // APB setup: registered read data and error
    if (apb_setup) begin
      st_nxt.pslverr = !reg_valid(apb.paddr);
      st_nxt.prdata  = 32'h00000000;
      if (!apb.pwrite) begin
        unique case (apb.paddr)
          dfa_pkg::OFF_SRC:    st_nxt.prdata = {dfa_pkg::TOP_BYTE, st_r.src};  // [R03]
          dfa_pkg::OFF_DST:    st_nxt.prdata = {dfa_pkg::TOP_BYTE, st_r.dst};  // [R03]
          dfa_pkg::OFF_CNT_A:  st_nxt.prdata = {16'h0000, st_r.cnt_a};
          dfa_pkg::OFF_CNT_B:  st_nxt.prdata = {16'h0000, st_r.cnt_b};
          dfa_pkg::OFF_CTL_A:  st_nxt.prdata = {24'h000000, st_r.ctl_a};
          dfa_pkg::OFF_CTL_B:  st_nxt.prdata = {24'h000000, st_r.ctl_b};
          dfa_pkg::OFF_STATUS: st_nxt.prdata = {26'h0000000, st_r.state,
                                                st_r.mid_block, st_r.req_pend,
                                                full_mode, enabled};
          default:             st_nxt.prdata = 32'h00000000;
        endcase
      end
    end

    // APB access: side effects and writes
    if (apb_acc && !st_r.pslverr) begin
      if (!apb.pwrite) begin
        if (apb.paddr == dfa_pkg::OFF_CTL_A && !st_r.ctl_a[dfa_pkg::CA_ENABLE]) begin
          st_nxt.arm_a = 1'b1;                                          // [R12]
        end
        if (apb.paddr == dfa_pkg::OFF_CTL_B && !st_r.ctl_b[dfa_pkg::CB_MASTER]) begin
          st_nxt.arm_b = 1'b1;                                          // [R12]
        end
      end else begin
        unique case (apb.paddr)
          dfa_pkg::OFF_SRC:   st_nxt.src   = apb.pwdata[23:0];          // [R03]
          dfa_pkg::OFF_DST:   st_nxt.dst   = apb.pwdata[23:0];          // [R03]
          dfa_pkg::OFF_CNT_A: st_nxt.cnt_a = apb.pwdata[15:0];
          dfa_pkg::OFF_CNT_B: st_nxt.cnt_b = apb.pwdata[15:0];
          dfa_pkg::OFF_CTL_A: begin
            wr_ctl = apb.pwdata[7:0];
            if (wr_ctl[dfa_pkg::CA_ENABLE] && !st_r.ctl_a[dfa_pkg::CA_ENABLE]
                && !st_r.arm_a) begin
              wr_ctl[dfa_pkg::CA_ENABLE] = 1'b0;                        // [R12]
            end
            st_nxt.ctl_a = wr_ctl;
            st_nxt.arm_a = 1'b0;
            // Clearing enable abandons a block in progress
            if (!wr_ctl[dfa_pkg::CA_ENABLE]) begin
              st_nxt.mid_block = 1'b0;
            end
          end
          dfa_pkg::OFF_CTL_B: begin
            wr_ctl = apb.pwdata[7:0];
            if (wr_ctl[dfa_pkg::CB_MASTER] && !st_r.ctl_b[dfa_pkg::CB_MASTER]
                && !st_r.arm_b) begin
              wr_ctl[dfa_pkg::CB_MASTER] = 1'b0;                        // [R12]
            end
            st_nxt.ctl_b = wr_ctl;
            st_nxt.arm_b = 1'b0;
          end
          default: ;
        endcase
      end
    end

    // NMI suspends; the block position is kept so a later set resumes it
    if (nmi) begin
      st_nxt.ctl_b[dfa_pkg::CB_MASTER] = 1'b0;                          // [R18]
      st_nxt.arm_b = 1'b0;
    end

    // Standby clears control, block position and pending request; addresses and counts keep their contents
    if (standby) begin
      st_nxt.ctl_a     = dfa_pkg::CTL_RESET;                            // [R17]
      st_nxt.ctl_b     = dfa_pkg::CTL_RESET;
      st_nxt.arm_a     = 1'b0;
      st_nxt.arm_b     = 1'b0;
      st_nxt.mid_block = 1'b0;
      st_nxt.req_pend  = 1'b0;
    end

    // A fall of the enable bit, by hardware or software, raises the end event when the new interrupt enable bit is 1
    st_nxt.irq = old_en & ~st_nxt.ctl_a[dfa_pkg::CA_ENABLE]
                 & st_nxt.ctl_a[dfa_pkg::CA_IRQ_EN];                    // [R13]
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Address and count fields get no reset value on purpose
  // Clock enable low freezes every field, APB capture too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.state     <= dfa_pkg::ST_IDLE;
      st_r.ctl_a     <= dfa_pkg::CTL_RESET;                             // [R17]
      st_r.ctl_b     <= dfa_pkg::CTL_RESET;
      st_r.arm_a     <= 1'b0;
      st_r.arm_b     <= 1'b0;
      st_r.mid_block <= 1'b0;
      st_r.req_d     <= 1'b0;
      st_r.req_pend  <= 1'b0;
      st_r.irq       <= 1'b0;
      st_r.prdata    <= 32'h00000000;
      st_r.pslverr   <= 1'b0;
      st_r.bus       <= '0;
    end else if (pclk_en) begin
      st_r <= st_nxt;                                                   // [R04]
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Zero wait states; slave error shows only in the access phase
  assign prdata                 = st_r.prdata;
  assign pslverr                = st_r.pslverr & apb_acc;
  assign pready                 = 1'b1;
  assign bus_req                = st_r.bus;
  assign transfer_end_interrupt = st_r.irq;
  assign busy                   = (st_r.state != dfa_pkg::ST_IDLE);

endmodule // dfa_channel

// File: test/dfa_channel_properties.sv
// Concurrent checks on the full-address DMA channel ports
module dfa_channel_properties (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  pclk_en,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic                  pslverr,
  input wire dfa_pkg::dfa_bus_req_t bus_req,
  input wire logic                  bus_ack,
  input wire logic [15:0]           bus_rdata,
  input wire logic                  transfer_end_interrupt,
  input wire logic                  busy
);
  // ==========================================================================
  // Bus master and register checks
  // ==========================================================================
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TOP_BYTE: assert property (bus_req.req |-> bus_req.addr[31:24] == 8'hff)
    else $error("bus address top byte not all ones");
  AST_READ_FIRST: assert property ($rose(bus_req.req) |-> !bus_req.write)
    else $error("transfer did not open with a read");
  AST_REQ_HOLD: assert property (bus_req.req && !bus_ack && pclk_en |=> $stable(bus_req))
    else $error("bus request changed before acceptance");
  AST_WDATA: assert property (bus_req.req && !bus_req.write && bus_req.word && bus_ack
    && pclk_en |=> bus_req.req && bus_req.write && bus_req.wdata == $past(bus_rdata))
    else $error("write does not carry the read word");
  AST_STEP_GAP: assert property (bus_req.req && bus_req.write && bus_ack && pclk_en
    |=> !bus_req.req) else $error("no update cycle after the write");
  AST_IDLE_QUIET: assert property (!busy |-> !bus_req.req)
    else $error("bus request while engine idle");
  AST_IRQ_PULSE: assert property (transfer_end_interrupt |=> !transfer_end_interrupt)
    else $error("end interrupt longer than one cycle");
  AST_SLVERR: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");

  cover property (transfer_end_interrupt);
  cover property (bus_req.req && bus_req.write && bus_req.word && bus_ack);
  cover property (psel && penable && pslverr);
endmodule // dfa_channel_properties

bind dfa_channel dfa_channel_properties u_props (.pclk(pclk), .presetn(presetn),
  .pclk_en(pclk_en), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .bus_req(bus_req), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
  .transfer_end_interrupt(transfer_end_interrupt), .busy(busy));

// File: test/dfa_mem_model.sv
// System bus memory model answering the channel's reads and writes
module dfa_mem_model (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire dfa_pkg::dfa_bus_req_t bus_req,
  input wire logic [1:0]            wait_cycles,
  output logic                      bus_ack,
  output logic [15:0]               bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Acceptance and read data
  // ==========================================================================
  logic [1:0]  cnt_r;
  logic [15:0] data_w;

  assign data_w = bus_req.addr[15:0] ^ 16'ha5c3;
  // Off-ack data inverted so a stale sample never looks right
  assign bus_rdata = bus_ack ? data_w : ~data_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      bus_ack <= 1'b0;
    end else if (bus_ack) begin
      bus_ack <= 1'b0;
      cnt_r <= 2'h0;
    end else if (bus_req.req && cnt_r >= wait_cycles) begin
      bus_ack <= 1'b1;
    end else if (bus_req.req) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule // dfa_mem_model

// File: test/tb_dfa_channel.sv
// Self-checking bench for the full-address DMA channel
module tb_dfa_channel;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Stimulus, model and monitor
  // ==========================================================================
  logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic                  standby = 0, treq = 0, nmi = 0, pready, pslverr, perr, bus_ack, irq, busy;
  logic [1:0]            wt = 0;
  logic [7:0]            paddr = 0;
  logic [15:0]           bus_rdata;
  logic [31:0]           pwdata = 0, prdata, rd, lsrc;
  logic [31:0]           q_src[$], q_dst[$];
  dfa_pkg::dfa_bus_req_t bus_req;
  int                    fail_count = 0, cmp_count = 0, seed = 5324, irqs = 0, irq0 = 0;

  always #50 pclk = ~pclk;

  dfa_channel DUT (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby(standby), .nmi(nmi),
    .transfer_request(treq), .bus_req(bus_req), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .transfer_end_interrupt(irq), .busy(busy));
  dfa_mem_model MEM (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .wait_cycles(wt),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  always @(posedge pclk) begin
    wt <= 2'($random(seed));
    if (irq === 1'b1) irqs++;
    if (presetn && bus_req.req === 1'b1 && bus_ack === 1'b1) begin
      if (!bus_req.write) begin
        lsrc = bus_req.addr;
        chk(bus_req.addr, q_src.pop_front());
      end else begin
        chk(bus_req.addr, q_dst.pop_front());
        if (bus_req.word) chk({16'h0, bus_req.wdata}, {16'h0, lsrc[15:0] ^ 16'ha5c3});
      end
    end
  end

  // Queues hold the expected address stream, block area rewound per block
  task automatic prog(input int n, input logic [7:0] ca, input logic [7:0] cb,
                      input logic [7:0] bs);
    logic [31:0] s, d, sb, db, st;
    st = ca[6] ? 32'h2 : 32'h1;
    s = 32'hff001000 + 32'(($random(seed) & 255) * 2);
    d = 32'hff008000 + 32'(($random(seed) & 255) * 2);
    irq0 = irqs;
    apb(1, dfa_pkg::OFF_SRC, s);
    apb(1, dfa_pkg::OFF_DST, d);
    apb(1, dfa_pkg::OFF_CNT_A, ca[0] ? {16'h0, bs, bs} : 32'(n));
    apb(1, dfa_pkg::OFF_CNT_B, 32'(n));
    for (int b = 0; b < (ca[0] ? n : 1); b++) begin
      sb = s;
      db = d;
      for (int i = 0; i < (ca[0] ? int'(bs) : n); i++) begin
        q_src.push_back(s);
        q_dst.push_back(d);
        if (ca[4]) s = ca[5] ? s - st : s + st;
        if (cb[4]) d = cb[5] ? d - st : d + st;
      end
      if (ca[0] && cb[3]) s = sb;
      else if (ca[0]) d = db;
    end
    apb(0, dfa_pkg::OFF_CTL_B, 0);
    apb(1, dfa_pkg::OFF_CTL_B, {24'h0, cb});
    apb(0, dfa_pkg::OFF_CTL_A, 0);
    apb(1, dfa_pkg::OFF_CTL_A, {24'h0, ca | 8'h80});
  endtask

  task automatic done(input logic [7:0] ca, input logic [15:0] ea);
    for (int k = 0; k < 300; k++) begin
      apb(0, dfa_pkg::OFF_CTL_A, 0);
      if (rd[7] === 1'b0) break;
    end
    chk(rd, {24'h0, ca});
    apb(0, dfa_pkg::OFF_CNT_A, 0);
    chk({16'h0, rd[15:0]}, {16'h0, ea});
    chk(32'(irqs - irq0), {31'h0, ca[3]});
    chk(32'(q_dst.size()), 32'h0);
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  ca;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, dfa_pkg::OFF_CTL_A, 0);
    chk(rd, 32'h0);
    apb(1, dfa_pkg::OFF_SRC, 32'h12345678);
    apb(0, dfa_pkg::OFF_SRC, 0);
    chk(rd, 32'hff345678);
    apb(0, 8'h1c, 0);
    chk(rd, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1, dfa_pkg::OFF_CTL_A, 32'h06);
    apb(1, dfa_pkg::OFF_CTL_A, 32'h86);
    apb(0, dfa_pkg::OFF_CTL_A, 0);
    chk(rd, 32'h06);
    prog(3, 8'h0e, 8'h07, 8'h0);
    treq <= 1;
    repeat (20) @(posedge pclk);
    chk({31'h0, busy}, 32'h0);
    treq <= 0;
    apb(0, dfa_pkg::OFF_CTL_B, 0);
    apb(1, dfa_pkg::OFF_CTL_B, 32'h87);
    repeat (20) @(posedge pclk);
    chk({31'h0, busy}, 32'h0);
    treq <= 1;
    done(8'h0e, 16'h0);
    treq <= 0;
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      ca = {1'b0, r[0], r[1], r[2], r[3], 2'b11, 1'b0};
      prog(int'(r[8:6]) + 1, ca, {2'b10, r[4], r[5], 2'b00, k[0], 1'b0}, 8'h0);
      done(ca, 16'h0);
    end
    for (int k = 0; k < 2; k++) begin
      ca = {1'b0, k[0], 6'h1f};
      prog(2, ca, {4'h9, k[0], 3'h6}, 8'h03);
      for (int b = 0; b < 2; b++) begin
        treq <= 1;
        @(posedge pclk);
        treq <= 0;
        for (int j = 0; j < 200 && q_dst.size() > (1 - b) * 3; j++) @(posedge pclk);
      end
      done(ca, 16'h0303);
      apb(0, dfa_pkg::OFF_CNT_B, 0);
      chk({16'h0, rd[15:0]}, 32'h0);
    end
    nmi <= 1;
    @(posedge pclk);
    nmi <= 0;
    apb(0, dfa_pkg::OFF_CTL_B, 0);
    chk(rd, 32'h1e);
    apb(1, dfa_pkg::OFF_SRC, 32'h00abcdef);
    apb(1, dfa_pkg::OFF_CTL_A, 32'h0e);
    apb(1, dfa_pkg::OFF_CTL_B, 32'h40);
    standby <= 1;
    repeat (2) @(posedge pclk);
    standby <= 0;
    apb(0, dfa_pkg::OFF_CTL_A, 0);
    chk(rd, 32'h0);
    apb(0, dfa_pkg::OFF_SRC, 0);
    chk(rd, 32'hffabcdef);
    wrap_up();
  end

  initial begin
    #(100 * 40000);
    fail_count++;
    wrap_up();
  end
endmodule // tb_dfa_channel
